/* inc/udr_regs.svh */
// Register offsets, field positions, reset values and counts of the serial port front end.
// Assumes inclusion by bare name from the package and the design file.
`ifndef UDR_REGS_SVH
`define UDR_REGS_SVH
// ****************************************************
// Register offsets
// ****************************************************
`define UDR_OFF_DATA    8'h00
`define UDR_OFF_RSR     8'h04
`define UDR_OFF_LCRH    8'h08
`define UDR_OFF_LCRM    8'h0c
`define UDR_OFF_LCRL    8'h10
`define UDR_OFF_CTRL    8'h14
`define UDR_OFF_FLAG    8'h18
`define UDR_OFF_IIR     8'h1c
`define UDR_OFF_ILPR    8'h20
// ****************************************************
// Reset values
// ****************************************************
`define UDR_RST_LCRH    7'h00
`define UDR_RST_BYTE    8'h00
`define UDR_RST_RSR     4'h0
// ****************************************************
// Field positions
// ****************************************************
`define UDR_CTRL_EN     0
`define UDR_CTRL_LBE    7
`define UDR_RSR_OVR     3
`define UDR_FLAG_BUSY   3
`define UDR_FLAG_RXFE   4
`define UDR_FLAG_TXFF   5
`define UDR_FLAG_RXFF   6
`define UDR_FLAG_TXFE   7
// ****************************************************
// Counts
// ****************************************************
`define UDR_FIFO_DEPTH  16
`define UDR_SUB_LAST    4'hf
`define UDR_SUB_MID     4'h7
`endif

/* inc/udr_pkg.sv */
// Types shared by the serial port front end.
// Assumes udr_regs.svh is on the include path.
`include "udr_regs.svh"
package udr_pkg;
   // Receive FIFO entry: error flags above the data byte
   typedef struct packed {
      logic       brk;
      logic       par;
      logic       frm;
      logic [7:0] data;
   } udr_rx_entry_t;
   // Combined 23-bit line control word
   typedef struct packed {
      logic [1:0]  wlen;
      logic        fen;
      logic        stp2;
      logic        even_parity_select;
      logic        pen;
      logic        brk;
      logic [15:0] div;
   } udr_lcr_t;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} udr_tx_st_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT_HI} udr_rx_st_t;
endpackage

/* design/udr_top.sv */
// Serial port register front end with transmit and receive engines and FIFOs.
// Assumes one 20 MHz clock, a synchronous register port and an asynchronous rxd pin.
//
// Functional notes
// [RQ1] Registers decode at fixed offsets from base
// [RQ2] Host avoids reserved and test offsets
// [RQ3] Data write pushes FIFO or holding register
// [RQ4] Sent with start, optional parity, stop
// [RQ5] Receive entry holds byte plus three flags
// [RQ6] Without FIFOs a single holding entry
// [RQ7] Data location: read oldest, write transmit
// [RQ8] Status shows flags of last popped char; the code ORs in the flags of every char popped since the last clear
// [RQ9] Host reads data before its status
// [RQ10] Host disables port before reprogramming control
// [RQ11] Any status write clears all errors
// [RQ12] Status bits zero after reset
// [RQ13] Status bits 7:4 reserved
// [RQ14] Overrun sets when full, FIFO kept
// [RQ15] Break when line low whole character
// [RQ16] Break loads one zero, waits high
// [RQ17] Parity error against even parity select
// [RQ18] Framing error when stop bit low
// [RQ19] FIFO flags belong to top character
// [RQ20] Flags in bits 10:8, overrun separate
// [RQ21] Line control commits on high write
// [RQ22] Reserved reads zero, writes ignored
// [RQ23] Errors sticky until clear or reset
`timescale 1ns/1ps
`default_nettype none
`include "udr_regs.svh"

// ****************************************************
// Synchronous FIFO
// ****************************************************
module udr_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic         one_deep,   // Character mode: act as one entry
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];          // Storage
   logic [AW-1:0] wp_r;             // Write pointer
   logic [AW-1:0] rp_r;             // Read pointer
   logic [AW:0]   cnt_r;            // Fill level
   logic          push;
   logic          pop;

   // Full is faked at one entry so the same storage serves as a holding register
   assign in_ready  = one_deep ? (cnt_r == '0) : (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage write
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   // Pointers and level
   always_ff @(posedge clock) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // udr_fifo

// ****************************************************
// Top level
// ****************************************************
module udr_top
   import udr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       reg_sel,     // Access strobe, one cycle per access
   input  wire logic       reg_wr,      // High for write
   input  wire logic [7:0] reg_addr,    // Byte offset from block base
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,   // Valid the cycle after a read strobe
   output logic            txd,
   input  wire logic       rxd,
   output logic            busy
);
   // ****************************************************
   // Register state
   // ****************************************************
   udr_lcr_t      lcr_r;             // Committed line control
   logic [7:0]    lcrm_r;            // Staged middle byte
   logic [7:0]    lcrl_r;            // Staged low byte
   logic [7:0]    ctrl_r;            // Port control
   logic [7:0]    ilpr_r;            // Low-power divisor, stored only
   logic [2:0]    err_r;             // Sticky brk/par/frm of popped chars
   logic          ovr_r;             // Sticky overrun
   logic          wr_en;
   logic          rd_en;
   logic          en;
   logic          ovr_evt;

   assign wr_en = reg_sel & reg_wr;
   assign rd_en = reg_sel & ~reg_wr;
   assign en    = ctrl_r[`UDR_CTRL_EN];

   // ****************************************************
   // FIFOs
   // ****************************************************
   logic          txf_in_ready;
   logic          txf_out_valid;
   logic          txf_out_ready;
   logic [7:0]    txf_out_data;
   logic          rxf_in_valid;
   logic          rxf_in_ready;
   udr_rx_entry_t rxf_in_data;
   logic          rxf_out_valid;
   logic          rxf_out_ready;
   udr_rx_entry_t rxf_out_data;

   // Transmit queue; a write while full is dropped, shown by the full flag
   udr_fifo #(.W(8), .D(`UDR_FIFO_DEPTH)) u_txf (
      .clock     (clock),
      .rst       (rst),
      .one_deep  (~lcr_r.fen),
      .in_valid  (wr_en && reg_addr == `UDR_OFF_DATA),  // RQ3
      .in_ready  (txf_in_ready),
      .in_data   (reg_wdata),
      .out_valid (txf_out_valid),
      .out_ready (txf_out_ready),
      .out_data  (txf_out_data)
   );

   // Receive queue of 11-bit entries
   udr_fifo #(.W(11), .D(`UDR_FIFO_DEPTH)) u_rxf (
      .clock     (clock),
      .rst       (rst),
      .one_deep  (~lcr_r.fen),                          // RQ6
      .in_valid  (rxf_in_valid),
      .in_ready  (rxf_in_ready),
      .in_data   (rxf_in_data),                         // RQ5 RQ20
      .out_valid (rxf_out_valid),
      .out_ready (rxf_out_ready),
      .out_data  (rxf_out_data)
   );

   // A data read pops the oldest character
   assign rxf_out_ready = rd_en && reg_addr == `UDR_OFF_DATA;  // RQ7

   // ****************************************************
   // Register writes
   // ****************************************************
   // Middle and low bytes are only staged; the high write commits all three
   always_ff @(posedge clock) begin
      if (rst) begin
         lcr_r  <= '0;
         lcrm_r <= `UDR_RST_BYTE;
         lcrl_r <= `UDR_RST_BYTE;
         ctrl_r <= `UDR_RST_BYTE;
         ilpr_r <= `UDR_RST_BYTE;
      end else if (wr_en) begin
         case (reg_addr)
            `UDR_OFF_LCRH: lcr_r <= {reg_wdata[6:0], lcrm_r, lcrl_r};  // RQ21
            `UDR_OFF_LCRM: lcrm_r <= reg_wdata;
            `UDR_OFF_LCRL: lcrl_r <= reg_wdata;
            `UDR_OFF_CTRL: ctrl_r <= reg_wdata;
            `UDR_OFF_ILPR: ilpr_r <= reg_wdata;
            default: ;  // Reserved offsets ignore writes  RQ22
         endcase
      end
   end

   // Error flags of popped characters accumulate until cleared
   always_ff @(posedge clock) begin
      if (rst) begin
         err_r <= '0;  // RQ12
      end else if (wr_en && reg_addr == `UDR_OFF_RSR) begin
         err_r <= '0;  // RQ11
      end else if (rxf_out_ready && rxf_out_valid) begin
         // Flags travel with their entry, so they are the top char's  RQ19
         err_r <= err_r | {rxf_out_data.brk, rxf_out_data.par, rxf_out_data.frm};  // RQ8 RQ23
      end
   end

   // Overrun: a new event wins over a clear in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         ovr_r <= 1'b0;  // RQ12
      end else if (ovr_evt) begin
         ovr_r <= 1'b1;  // RQ14 RQ23
      end else if (wr_en && reg_addr == `UDR_OFF_RSR) begin
         ovr_r <= 1'b0;  // RQ11
      end
   end

   // ****************************************************
   // Register reads
   // ****************************************************
   // Read data is registered; unmapped and reserved offsets return zero
   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (rd_en) begin
         case (reg_addr)  // RQ1
            `UDR_OFF_DATA: reg_rdata <= rxf_out_data.data;  // RQ7
            `UDR_OFF_RSR:  reg_rdata <= {4'h0, ovr_r, err_r};  // RQ13
            `UDR_OFF_LCRH: reg_rdata <= {1'b0, lcr_r[22:16]};
            `UDR_OFF_LCRM: reg_rdata <= lcrm_r;
            `UDR_OFF_LCRL: reg_rdata <= lcrl_r;
            `UDR_OFF_CTRL: reg_rdata <= ctrl_r;
            `UDR_OFF_FLAG: reg_rdata <= {txf_out_valid == 1'b0, ~rxf_in_ready,
                                         ~txf_in_ready, ~rxf_out_valid, busy, 3'h0};
            `UDR_OFF_IIR:  reg_rdata <= '0;
            `UDR_OFF_ILPR: reg_rdata <= ilpr_r;
            default:       reg_rdata <= '0;  // RQ22
         endcase
      end
   end

   // ****************************************************
   // Baud generator
   // ****************************************************
   logic [15:0] bcnt_r;  // Down counter
   logic        tick;    // One pulse per sixteenth of a bit

   // A zero divisor stops both engines
   assign tick = en && (lcr_r.div != 16'h0000) && (bcnt_r == 16'h0000);

   // Reload on reaching zero
   always_ff @(posedge clock) begin
      if (rst) begin
         bcnt_r <= '0;
      end else if (!en || bcnt_r == 16'h0000) begin
         bcnt_r <= lcr_r.div;
      end else begin
         bcnt_r <= bcnt_r - 16'h0001;
      end
   end

   // ****************************************************
   // Transmitter
   // ****************************************************
   udr_tx_st_t tx_st_r;
   logic [3:0] tx_sub_r;   // Tick count within a bit
   logic [2:0] tx_bit_r;   // Data bit index
   logic [7:0] tx_sh_r;    // Shift register
   logic       tx_par_r;   // Parity bit to send
   logic       tx_end;     // Last tick of a bit
   logic [2:0] nbits_m1;   // Data bits minus one

   assign nbits_m1      = {1'b1, lcr_r.wlen};
   assign tx_end        = tick && tx_sub_r == `UDR_SUB_LAST;
   // Start only on a bit boundary so the first bit has a full length
   assign txf_out_ready = (tx_st_r == TX_IDLE) && tick && !lcr_r.brk;
   assign busy          = txf_out_valid || (tx_st_r != TX_IDLE);

   // Frame sequencer
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_st_r  <= TX_IDLE;
         tx_sub_r <= '0;
         tx_bit_r <= '0;
         tx_sh_r  <= '0;
         tx_par_r <= 1'b0;
      end else begin
         if (tick) begin
            tx_sub_r <= tx_sub_r + 4'h1;
         end
         case (tx_st_r)
            TX_IDLE: begin
               if (txf_out_ready && txf_out_valid) begin
                  tx_st_r  <= TX_START;  // RQ4
                  tx_sub_r <= 4'h0;
                  tx_sh_r  <= txf_out_data;
                  // Even parity makes the one count even
                  tx_par_r <= ^(txf_out_data & ~(8'hff << (5 + lcr_r.wlen))) ^ ~lcr_r.even_parity_select;
                  tx_bit_r <= '0;
               end else if (tick) begin
                  tx_sub_r <= '0;
               end
            end
            TX_START: if (tx_end) tx_st_r <= TX_DATA;
            TX_DATA: begin
               if (tx_end) begin
                  tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                  tx_bit_r <= tx_bit_r + 3'h1;
                  if (tx_bit_r == nbits_m1) begin
                     tx_st_r <= lcr_r.pen ? TX_PAR : TX_STOP1;  // RQ4
                  end
               end
            end
            TX_PAR:   if (tx_end) tx_st_r <= TX_STOP1;
            TX_STOP1: if (tx_end) tx_st_r <= lcr_r.stp2 ? TX_STOP2 : TX_IDLE;
            TX_STOP2: if (tx_end) tx_st_r <= TX_IDLE;
            default:  tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // Line driver; break holds the line low once idle
   always_ff @(posedge clock) begin
      if (rst) begin
         txd <= 1'b1;
      end else begin
         case (tx_st_r)
            TX_START: txd <= 1'b0;
            TX_DATA:  txd <= tx_sh_r[0];
            TX_PAR:   txd <= tx_par_r;
            TX_IDLE:  txd <= !lcr_r.brk;
            default:  txd <= 1'b1;
         endcase
      end
   end

   // ****************************************************
   // Receive input synchroniser
   // ****************************************************
   logic rx_s1_r;   // First stage, read only by the second
   logic rx_s2_r;
   logic rx_s3_r;
   logic rx_lvl_r;  // Accepted level
   logic rx_in;

   // Three stages; a change is taken once stages two and three agree
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_s1_r  <= 1'b1;
         rx_s2_r  <= 1'b1;
         rx_s3_r  <= 1'b1;
         rx_lvl_r <= 1'b1;
      end else begin
         rx_s1_r <= rxd;
         rx_s2_r <= rx_s1_r;
         rx_s3_r <= rx_s2_r;
         if (rx_s2_r == rx_s3_r) begin
            rx_lvl_r <= rx_s3_r;
         end
      end
   end

   // Loopback feeds the transmitter straight back, same clock
   assign rx_in = ctrl_r[`UDR_CTRL_LBE] ? txd : rx_lvl_r;

   // ****************************************************
   // Receiver
   // ****************************************************
   udr_rx_st_t rx_st_r;
   logic [3:0] rx_sub_r;   // Tick count within a bit
   logic [2:0] rx_bit_r;
   logic [7:0] rx_sh_r;
   logic       rx_par_r;   // Received parity bit
   logic       rx_smp;     // Sample point
   logic       rx_zero;    // Data and parity all low
   logic       rx_perr;

   assign rx_smp  = tick && rx_sub_r == `UDR_SUB_LAST;
   assign rx_zero = (rx_sh_r == 8'h00) && !(lcr_r.pen && rx_par_r);
   // Expected one count parity: even select wants even total
   assign rx_perr = lcr_r.pen && ((^rx_sh_r ^ rx_par_r) != ~lcr_r.even_parity_select);  // RQ17
   // Character completes at stop sample; a full FIFO drops it
   assign rxf_in_valid = (rx_st_r == RX_STOP) && rx_smp;
   assign ovr_evt      = rxf_in_valid && !rxf_in_ready;  // RQ14

   // Entry built at the stop sample; a break forces an all-zero character
   always_comb begin
      rxf_in_data      = '0;
      rxf_in_data.data = rx_sh_r;
      rxf_in_data.frm  = !rx_in;  // RQ18
      rxf_in_data.par  = rx_perr;
      if (!rx_in && rx_zero) begin
         rxf_in_data     = '0;    // RQ16
         rxf_in_data.brk = 1'b1;  // RQ15
      end
   end

   // Frame receiver
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_st_r  <= RX_IDLE;
         rx_sub_r <= '0;
         rx_bit_r <= '0;
         rx_sh_r  <= '0;
         rx_par_r <= 1'b0;
      end else begin
         if (tick) begin
            rx_sub_r <= rx_sub_r + 4'h1;
         end
         case (rx_st_r)
            RX_IDLE: begin
               if (tick && !rx_in) begin
                  rx_st_r  <= RX_START;
                  rx_sub_r <= 4'h1;
               end
            end
            RX_START: begin
               // Mid-bit check rejects glitches; later samples fall mid-bit
               if (tick && rx_sub_r == `UDR_SUB_MID) begin
                  rx_st_r  <= rx_in ? RX_IDLE : RX_DATA;
                  rx_sub_r <= '0;
                  rx_bit_r <= '0;
                  rx_sh_r  <= '0;
               end
            end
            RX_DATA: begin
               if (rx_smp) begin
                  rx_sh_r[rx_bit_r] <= rx_in;
                  rx_bit_r <= rx_bit_r + 3'h1;
                  if (rx_bit_r == nbits_m1) begin
                     rx_st_r <= lcr_r.pen ? RX_PAR : RX_STOP;
                  end
               end
            end
            RX_PAR: begin
               if (rx_smp) begin
                  rx_par_r <= rx_in;
                  rx_st_r  <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_smp) begin
                  // A low stop level, break or not, must see marking before a new start
                  rx_st_r <= rx_in ? RX_IDLE : RX_WAIT_HI;  // RQ16
               end
            end
            RX_WAIT_HI: if (rx_in) rx_st_r <= RX_IDLE;
            default:    rx_st_r <= RX_IDLE;
         endcase
      end
   end
endmodule // udr_top

`default_nettype wire

/* tb/udr_top_assertions.sv */
// Checker for the serial port register front end.
// Assumes a bind to udr_top; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module udr_top_chk (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       reg_sel,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       txd,
   input wire logic       busy
);
   // ****************
   // Decode helpers
   // ****************
   logic rd_c;   // Read strobe this cycle
   logic wr_c;   // Write strobe this cycle
   assign rd_c = reg_sel && !reg_wr;
   assign wr_c = reg_sel && reg_wr;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ****************
   // Properties
   // ****************
   // Outputs idle right after reset leaves
   property p_rst_out; $fell(rst) |-> reg_rdata == 8'h00 && txd && !busy; endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
   property p_resv_rd; rd_c && reg_addr >= 8'h24 |=> reg_rdata == 8'h00; endproperty
   a_resv_rd: assert property (p_resv_rd) else $error("reserved read not zero");
   property p_rsr_hi; rd_c && reg_addr == 8'h04 |=> reg_rdata[7:4] == 4'h0; endproperty
   a_rsr_hi: assert property (p_rsr_hi) else $error("status upper bits set");
   property p_flag_lo; rd_c && reg_addr == 8'h18 |=> reg_rdata[2:0] == 3'h0; endproperty
   a_flag_lo: assert property (p_flag_lo) else $error("flag low bits set");
   // Clear then read back: error bits gone
   property p_clr;
      wr_c && reg_addr == 8'h04 ##2 rd_c && reg_addr == 8'h04 |=> reg_rdata[2:0] == 3'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("errors not cleared");
   // High line control byte reads back what was committed
   property p_lcrh;
      wr_c && reg_addr == 8'h08 ##2 rd_c && reg_addr == 8'h08
         |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 3)};
   endproperty
   a_lcrh: assert property (p_lcrh) else $error("line control high readback wrong");
   property p_ctl;
      wr_c && reg_addr == 8'h14 ##2 rd_c && reg_addr == 8'h14 |=> reg_rdata == $past(reg_wdata, 3);
   endproperty
   a_ctl: assert property (p_ctl) else $error("control readback wrong");
   property p_busy_wr; wr_c && reg_addr == 8'h00 |=> busy; endproperty
   a_busy_wr: assert property (p_busy_wr) else $error("busy low after data write");
   // Last frame ends on a stop level
   property p_busy_end; $fell(busy) |-> txd; endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy fell with line low");
   // Read data stands until the next read
   property p_hold; !rd_c |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule // udr_top_chk
bind udr_top udr_top_chk chk_u (.clock(clock), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .txd(txd),
   .busy(busy));
`default_nettype wire

/* tb/udr_line_peer.sv */
// Serial line peer: sends frames on rxd, captures frames from txd.
// Assumes 8 data bits, parity on, BIT clocks per bit.
`timescale 1ns/1ps
`default_nettype none
module udr_line_peer #(
   parameter int BIT = 32
) (
   input  wire logic clock,
   input  wire logic txd,
   output logic      rxd
);
   // Line marks high while idle
   initial rxd = 1'b1;
   // One frame LSB first; bad flips parity, stp is the stop level
   task automatic send(input logic [7:0] d, input logic bad, input logic stp);
      logic [10:0] f;
      f = {stp, ^d ^ bad, d, 1'b0};
      @(posedge clock);
      for (int i = 0; i < 11; i++) begin
         rxd <= f[i];
         repeat (BIT) @(posedge clock);
      end
      rxd <= 1'b1;
      repeat (BIT) @(posedge clock);
   endtask
   // Hold the line low for n bit times, then mark
   task automatic hold(input int n);
      @(posedge clock);
      rxd <= 1'b0;
      repeat (n * BIT) @(posedge clock);
      rxd <= 1'b1;
      repeat (2 * BIT) @(posedge clock);
   endtask
   // Capture one frame at mid-bit; returns early on the stop bit
   task automatic grab(output logic [10:0] f, output logic ok);
      int n;
      n = 0;
      while (txd !== 1'b0 && n < 2000) begin
         @(posedge clock);
         n++;
      end
      ok = (n < 2000);
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < 11; i++) begin
         f[i] = txd;
         if (i < 10) begin
            repeat (BIT) @(posedge clock);
         end
      end
   endtask
endmodule // udr_line_peer
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the serial port register front end.
// Assumes udr_top, udr_line_peer and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int BIT = 32;          // Clocks per bit at divisor 1
   logic        clock;               // 50 ns clock
   logic        rst;                 // Synchronous reset
   logic        reg_sel;             // Access strobe
   logic        reg_wr;              // Write select
   logic [7:0]  reg_addr;            // Offset
   logic [7:0]  reg_wdata;           // Write data
   logic [7:0]  reg_rdata;           // Read data
   logic        txd;                 // Serial out
   logic        rxd;                 // Serial in
   logic        busy;                // Transmit activity
   int          mismatches;          // Failed compares
   int          compares;            // All compares
   logic [10:0] frm;                 // Captured frame
   logic        ok;                  // Start bit seen
   logic [7:0]  zoffs [10] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20,
                               8'h24, 8'h40, 8'h9c};
   logic [7:0]  txv [2] = '{8'h41, 8'h07};
   // Receive table: data, bad parity, stop level, expected status
   logic [17:0] rxt [4] = '{{8'ha5, 2'b01, 8'h00}, {8'h3c, 2'b11, 8'h02},
                            {8'h5a, 2'b01, 8'h02}, {8'h11, 2'b00, 8'h03}};
   // Clock generator
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   udr_top dut_u (.clock(clock), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .txd(txd),
      .rxd(rxd), .busy(busy));
   udr_line_peer #(.BIT(BIT)) peer_u (.clock(clock), .txd(txd), .rxd(rxd));
   // ****************
   // Tasks
   // ****************
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One write strobe, then release on the next edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_sel   <= 1'b1;
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_sel   <= 1'b0;
   endtask
   // Read and compare; data is settled by the falling edge
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_sel  <= 1'b1;
      reg_wr   <= 1'b0;
      reg_addr <= a;
      @(posedge clock);
      reg_sel  <= 1'b0;
      @(negedge clock);
      chk($sformatf("reg %h", a), {3'h0, reg_rdata}, {3'h0, exp});
   endtask
   // ****************
   // Main sequence
   // ****************
   initial begin
      rst = 1'b1;
      reg_sel = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      mismatches = 0;
      compares = 0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      begin : scen
         foreach (zoffs[i]) rc(zoffs[i], 8'h00);
         rc(8'h18, 8'h90);
         wr(8'h24, 8'hff);
         wr(8'h9c, 8'hff);
         rc(8'h14, 8'h00);
         // Port is off, so line control may change; high byte last
         wr(8'h10, 8'h01);
         wr(8'h0c, 8'h00);
         rc(8'h10, 8'h01);
         wr(8'h08, 8'h76);
         rc(8'h08, 8'h76);
         wr(8'h20, 8'h5a);
         rc(8'h20, 8'h5a);
         wr(8'h14, 8'h01);
         rc(8'h14, 8'h01);
         // Two bytes back to back through the transmit FIFO
         wr(8'h00, txv[0]);
         wr(8'h00, txv[1]);
         @(negedge clock);
         chk("busy", {10'h0, busy}, 11'h001);
         foreach (txv[i]) begin
            peer_u.grab(frm, ok);
            // A start bit that never comes counts once and ends the run
            if (!ok) begin
               mismatches++;
               disable scen;
            end
            chk("tx frame", frm, {1'b1, ^txv[i], txv[i], 1'b0});
         end
         // Data read always precedes its status read
         foreach (rxt[i]) begin
            peer_u.send(rxt[i][17:10], rxt[i][9], rxt[i][8]);
            rc(8'h00, rxt[i][17:10]);
            rc(8'h04, rxt[i][7:0]);
         end
         wr(8'h04, 8'h5a);
         rc(8'h04, 8'h00);
         // Break: one zero entry only
         peer_u.hold(14);
         rc(8'h00, 8'h00);
         rc(8'h04, 8'h04);
         rc(8'h18, 8'h90);
         wr(8'h04, 8'h00);
         // Seventeen characters into sixteen places
         for (int i = 0; i < 17; i++) peer_u.send(8'h20 + 8'(i), 1'b0, 1'b1);
         rc(8'h18, 8'hc0);
         for (int i = 0; i < 16; i++) rc(8'h00, 8'h20 + 8'(i));
         rc(8'h04, 8'h08);
         // Character mode: one holding entry
         wr(8'h14, 8'h00);
         wr(8'h04, 8'h00);
         wr(8'h08, 8'h66);
         wr(8'h14, 8'h01);
         peer_u.send(8'h77, 1'b0, 1'b1);
         peer_u.send(8'h88, 1'b0, 1'b1);
         rc(8'h00, 8'h77);
         rc(8'h04, 8'h08);
         rc(8'h18, 8'h90);
         // Loopback: the byte sent comes back to the receiver
         wr(8'h14, 8'h00);
         wr(8'h14, 8'h81);
         wr(8'h00, 8'h3e);
         repeat (12 * BIT) @(posedge clock);
         rc(8'h00, 8'h3e);
      end
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
